// >>> src/rms_regs.vh
// Register offsets, field positions and reset values of the receive mode block
`ifndef RMS_REGS_VH
`define RMS_REGS_VH
`define RMS_OFF_RX_MODE      8'h23
`define RMS_OFF_SELFTEST     8'h24
`define RMS_OFF_LINK_CTRL    8'h30
`define RMS_OFF_LINK_STAT    8'h34
`define RMS_BIT_RATE_HALVE   6
`define RMS_BIT_AUTO_AUDIO   5
`define RMS_BIT_FAST_RATE    4
`define RMS_BIT_COAX         3
`define RMS_BIT_REPEATER     2
`define RMS_ST_RESET         8'h08
`define RMS_BIT_ST_PIN       3
`define RMS_BIT_ST_EN        0
`define RMS_BIT_AUTO_CLK     5
`define RMS_FAST_RATE_MBPS   20
`define RMS_CLK_MHZ          100
`define RMS_RATE_50          2'h0
`define RMS_RATE_25          2'h1
`define RMS_RATE_10          2'h2
`define RMS_REMOTE_CLKSRC    8'h14
`define RMS_RESP_OKAY        2'h0
`define RMS_RESP_SLVERR      2'h2
`endif

// >>> src/rms_strap_latch.v
// Strap capture one cycle after reset release
`timescale 1ns/1ps
`default_nettype none
module rms_strap_latch (
  input  wire aclk,
  input  wire aresetn,
  input  wire strap_in,
  output reg  strap_q_r,
  output reg  strap_load_r
);
  reg done_r;
  // Strap sampled by clocked logic after release, never by reset itself
  always @(posedge aclk) begin
    if (!aresetn) begin
      done_r       <= 1'b0;
      strap_q_r    <= 1'b0;
      strap_load_r <= 1'b0;
    end else begin
      strap_load_r <= ~done_r;
      if (!done_r) begin
        strap_q_r <= strap_in;
        done_r    <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> src/rms_remote_wr.v
// One-shot request to write the clock source into the remote serializer
`timescale 1ns/1ps
`default_nettype none
`include "rms_regs.vh"
module rms_remote_wr (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       start,
  input  wire [1:0] clk_src,
  input  wire       ack,
  output reg        req_r,
  output reg  [7:0] addr_r,
  output reg  [7:0] data_r
);
  // Request holds until the link side acknowledges
  always @(posedge aclk) begin
    if (!aresetn) begin
      req_r  <= 1'b0;
      addr_r <= 8'h00;
      data_r <= 8'h00;
    end else if (start) begin
      req_r  <= 1'b1;
      addr_r <= `RMS_REMOTE_CLKSRC;
      data_r <= {6'h00, clk_src};
    end else if (ack) begin
      req_r  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> src/rms_top.v
// Receive mode and self-test registers behind an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "rms_regs.vh"
// Overview of operation
// - Rate bit picks divide-by-four or two
// - Rate bit ignored while fast rate set
// - Fast rate gives 20Mbps, strap reset
// - Autodetect audio format from auxiliary codes
// - Cable type bit: twisted pair/coax, strap
// - Repeater bit read-only, latched from strap
// - Oscillator rate field: 50/25/10 MHz
// - Self test from pin or register
// - Clock source written to remote after enable
// - Self-test register resets to 08h
module rms_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        first_mode_strap_pin,
  input  wire        selftest_pin,
  input  wire        aux_audio_valid,
  input  wire [1:0]  aux_audio_code,
  input  wire        remote_wr_ack,
  output reg  [7:0]  oscillator_divider_div_r,
  output reg         back_channel_fast_rate_r,
  output reg         coax_mode_r,
  output reg  [1:0]  audio_mode_r,
  output reg  [1:0]  oscillator_rx_clock_rate_r,
  output reg  [5:0]  rx_clock_mhz_r,
  output reg         selftest_active_r,
  output reg  [2:0]  selftest_cfg_r,
  output reg         remote_wr_req_r,
  output reg  [7:0]  remote_wr_addr_r,
  output reg  [7:0]  remote_wr_data_r
);
  // Register state
  reg        rate_halve_r;
  reg        auto_audio_r;
  reg        fast_r;
  reg        coax_r;
  reg        repeater_r;
  reg  [1:0] rx_low_r;
  reg  [7:0] st_r;
  reg  [7:0] divider_r;
  reg        auto_clk_r;
  reg  [1:0] audio_det_r;
  reg        st_en_d_r;
  reg  [7:0] aw_r;
  reg        aw_have_r;
  reg  [31:0] w_r;
  reg  [3:0] ws_r;
  reg        w_have_r;
  wire       strap_q;
  wire       strap_load;
  wire       rw_req;
  wire [7:0] rw_addr;
  wire [7:0] rw_data;
  wire       st_start;
  wire       do_wr;
  wire [7:0] rx_mode_rd;
  wire       st_en_eff;

  rms_strap_latch u_strap (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .strap_in     (first_mode_strap_pin),
    .strap_q_r    (strap_q),
    .strap_load_r (strap_load)
  );

  // Rising edge of the effective enable starts the remote write
  assign st_en_eff = st_r[`RMS_BIT_ST_PIN] ? selftest_pin : st_r[`RMS_BIT_ST_EN];
  assign st_start  = st_en_eff & ~st_en_d_r;

  rms_remote_wr u_rwr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (st_start),
    .clk_src (st_r[2:1]),
    .ack     (remote_wr_ack),
    .req_r   (rw_req),
    .addr_r  (rw_addr),
    .data_r  (rw_data)
  );

  assign do_wr = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign rx_mode_rd = {1'b0, rate_halve_r, auto_audio_r, fast_r, coax_r, repeater_r, rx_low_r};

  // Write channels taken independently, response after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RMS_RESP_OKAY;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_r          <= 8'h00;
      w_r           <= 32'h0;
      ws_r          <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r          <= s_axi_awaddr;
        aw_have_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_r          <= s_axi_wdata;
        ws_r         <= s_axi_wstrb;
        w_have_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        case ({2'b00, aw_r[7:2]})
          `RMS_OFF_RX_MODE >> 2,
          `RMS_OFF_SELFTEST >> 2,
          `RMS_OFF_LINK_CTRL >> 2,
          `RMS_OFF_LINK_STAT >> 2: s_axi_bresp <= `RMS_RESP_OKAY;
          default:                 s_axi_bresp <= `RMS_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register file; offset 0x23 is not word aligned so it decodes on the word
  always @(posedge aclk) begin
    if (!aresetn) begin
      rate_halve_r <= 1'b0;
      auto_audio_r <= 1'b1;
      fast_r       <= 1'b0;
      coax_r       <= 1'b0;
      repeater_r   <= 1'b0;
      rx_low_r     <= 2'h0;
      st_r         <= `RMS_ST_RESET;
      divider_r    <= 8'h00;
      auto_clk_r   <= 1'b0;
    end else begin
      // Strap load lands two cycles after release and wins over a software write landing at the same edge
      if (strap_load) begin
        fast_r     <= strap_q;
        coax_r     <= strap_q;
        repeater_r <= strap_q;
      end else if (do_wr && ws_r[0]) begin
        case ({2'b00, aw_r[7:2]})
          `RMS_OFF_RX_MODE >> 2: begin
            rate_halve_r <= w_r[`RMS_BIT_RATE_HALVE];
            auto_audio_r <= w_r[`RMS_BIT_AUTO_AUDIO];
            fast_r       <= w_r[`RMS_BIT_FAST_RATE];
            coax_r       <= w_r[`RMS_BIT_COAX];
            rx_low_r     <= w_r[1:0];
          end
          `RMS_OFF_SELFTEST >> 2: st_r <= w_r[7:0];
          `RMS_OFF_LINK_CTRL >> 2: begin
            divider_r  <= w_r[7:0];
            auto_clk_r <= w_r[8 + `RMS_BIT_AUTO_CLK];
          end
          default: ;
        endcase
      end
    end
  end

  // Read channel, one wait state; bits above 8 read zero except link control and receive mode words
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `RMS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `RMS_RESP_OKAY;
        case ({2'b00, s_axi_araddr[7:2]})
          `RMS_OFF_RX_MODE >> 2:   s_axi_rdata <= {rx_mode_rd, 24'h0};
          `RMS_OFF_SELFTEST >> 2:  s_axi_rdata <= {24'h0, st_r};
          `RMS_OFF_LINK_CTRL >> 2: s_axi_rdata <= {16'h0, 2'h0, auto_clk_r, 5'h0, divider_r};
          `RMS_OFF_LINK_STAT >> 2: s_axi_rdata <= {24'h0, 3'h0, rw_req, 1'b0,
                                                   selftest_active_r, audio_mode_r};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RMS_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Audio mode detector; holds last code when autodetect is off
  always @(posedge aclk) begin
    if (!aresetn) begin
      audio_det_r <= 2'h0;
    end else if (auto_audio_r && aux_audio_valid) begin
      audio_det_r <= aux_audio_code;
    end
  end

  // Derived link controls, all registered outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      oscillator_divider_div_r   <= 8'h00;
      back_channel_fast_rate_r   <= 1'b0;
      coax_mode_r                <= 1'b0;
      audio_mode_r               <= 2'h0;
      oscillator_rx_clock_rate_r <= 2'h0;
      rx_clock_mhz_r             <= 6'd0;
      selftest_active_r          <= 1'b0;
      selftest_cfg_r             <= 3'h0;
      st_en_d_r                  <= 1'b0;
      remote_wr_req_r            <= 1'b0;
      remote_wr_addr_r           <= 8'h00;
      remote_wr_data_r           <= 8'h00;
    end else begin
      // Fast rate wins; rate bit only shapes the divider otherwise
      back_channel_fast_rate_r <= fast_r;
      if (fast_r) begin
        oscillator_divider_div_r <= 8'h00;
      end else if (rate_halve_r) begin
        oscillator_divider_div_r <= {1'b0, divider_r[7:1]};
      end else begin
        oscillator_divider_div_r <= {2'b00, divider_r[7:2]};
      end
      coax_mode_r  <= coax_r;
      audio_mode_r <= audio_det_r;
      oscillator_rx_clock_rate_r <= st_r[5:4];
      // Reserved code reports zero so a consumer can spot it
      if (!auto_clk_r) begin
        rx_clock_mhz_r <= 6'd0;
      end else begin
        case (st_r[5:4])
          `RMS_RATE_50: rx_clock_mhz_r <= 6'd50;
          `RMS_RATE_25: rx_clock_mhz_r <= 6'd25;
          `RMS_RATE_10: rx_clock_mhz_r <= 6'd10;
          default:      rx_clock_mhz_r <= 6'd0;
        endcase
      end
      st_en_d_r         <= st_en_eff;
      selftest_active_r <= st_en_eff;
      selftest_cfg_r    <= st_r[`RMS_BIT_ST_PIN] ? {2'b00, selftest_pin} : st_r[2:0];
      // Drop on the ack itself so the far side never sees a stale request
      remote_wr_req_r   <= rw_req & ~remote_wr_ack;
      remote_wr_addr_r  <= rw_addr;
      remote_wr_data_r  <= rw_data;
    end
  end
endmodule
`default_nettype wire

// >>> tb/rms_top_properties.sv
// Timing checks on the ports of the receive mode block
`timescale 1ns/1ps
`default_nettype none
module rms_top_properties (
  input wire logic       aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic       s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
  input wire logic       s_axi_arready, s_axi_rvalid, back_channel_fast_rate_r,
  input wire logic       selftest_active_r, remote_wr_req_r, remote_wr_ack,
  input wire logic [7:0] oscillator_divider_div_r, remote_wr_addr_r,
  input wire logic [1:0] oscillator_rx_clock_rate_r,
  input wire logic [5:0] rx_clock_mhz_r
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write halves taken at one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Remote request still unanswered
  sequence rem_wait;
    remote_wr_req_r && !remote_wr_ack;
  endsequence
  wr_resp_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  // Past value used although the divider is registered from fast_r at the same edge as the fast bit
  fast_div_a: assert property (back_channel_fast_rate_r && $past(back_channel_fast_rate_r)
    |-> oscillator_divider_div_r == 8'h00) else $error("divider not overridden");
  osc_map_a: assert property ($stable(oscillator_rx_clock_rate_r) && rx_clock_mhz_r != 6'h00
    |-> rx_clock_mhz_r == (oscillator_rx_clock_rate_r == 2'h0 ? 6'h32 :
    oscillator_rx_clock_rate_r == 2'h1 ? 6'h19 : 6'h0a)) else $error("clock rate wrong");
  osc_rsv_a: assert property ($stable(oscillator_rx_clock_rate_r) &&
    oscillator_rx_clock_rate_r == 2'h3 |-> rx_clock_mhz_r == 6'h00) else $error("reserved rate");
  rem_addr_a: assert property (remote_wr_req_r |-> remote_wr_addr_r == 8'h14)
    else $error("remote address wrong");
  rem_hold_a: assert property (rem_wait |=> remote_wr_req_r)
    else $error("remote request dropped");
  rem_start_a: assert property ($rose(remote_wr_req_r) |-> selftest_active_r)
    else $error("remote write without self test");
endmodule
bind rms_top rms_top_properties u_props (.*);
`default_nettype wire

// >>> tb/rms_remote_model.sv
// Remote serializer answering clock-source writes, promptly or slowly
`timescale 1ns/1ps
`default_nettype none
module rms_remote_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       remote_wr_req_r,
  input  wire logic [7:0] remote_wr_addr_r,
  input  wire logic [7:0] remote_wr_data_r,
  input  wire logic       rem_slow,
  output var  logic       remote_wr_ack = 1'b0,
  output var  logic [1:0] rem_clk_src
);
  logic [2:0] cnt_r;
  // Auto-acknowledge; slow mode waits four cycles before answering
  always @(posedge aclk) begin
    remote_wr_ack <= 1'b0;
    if (!aresetn) begin
      cnt_r <= 3'h0;
      rem_clk_src <= 2'h0;
    end else if (remote_wr_req_r && !remote_wr_ack) begin
      cnt_r <= cnt_r + 3'h1;
      if (cnt_r == (rem_slow ? 3'h3 : 3'h0)) begin
        remote_wr_ack <= 1'b1;
        cnt_r <= 3'h0;
        if (remote_wr_addr_r == 8'h14) rem_clk_src <= remote_wr_data_r[1:0];
      end
    end else cnt_r <= 3'h0;
  end
endmodule
`default_nettype wire

// >>> tb/test_rms_top.sv
// Self-checking bench for the receive mode and self-test registers
`timescale 1ns/1ps
`default_nettype none
module test_rms_top;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rem_slow = 1'b0;
  logic first_mode_strap_pin = 1'b1, selftest_pin = 1'b0, aux_audio_valid = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] aux_audio_code = 2'h0, s_axi_bresp, s_axi_rresp, resp, audio_mode_r;
  logic [1:0] oscillator_rx_clock_rate_r, rem_clk_src;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, remote_wr_ack;
  logic back_channel_fast_rate_r, coax_mode_r, selftest_active_r, remote_wr_req_r;
  logic [7:0] oscillator_divider_div_r, remote_wr_addr_r, remote_wr_data_r;
  logic [5:0] rx_clock_mhz_r;
  logic [2:0] selftest_cfg_r;
  int miscompares = 0, total_checks = 0;
  rms_top uut (.*);
  rms_remote_model far_end (.*);
  always #5 aclk = ~aclk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Both write channels offered together, each released once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) aw = 1'b0;
      if (s_axi_wready === 1'b1) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task aux(input logic [1:0] c);
    aux_audio_code <= c;
    aux_audio_valid <= 1'b1;
    @(posedge aclk);
    aux_audio_valid <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  // Strap bits high; mode byte sits in lane 3
  task t_reset;
    rd(8'h24);
    chk(rv, 32'h08);
    rd(8'h20);
    chk(rv, 32'h3c000000);
    chk(coax_mode_r, 1'b1);
    rd(8'h40);
    chk({resp, rv[29:0]}, 32'h80000000);
    $display("t_reset done");
  endtask
  // Audio mode follows codes only while autodetect is set
  task t_audio;
    aux(2'h2);
    chk(audio_mode_r, 2'h2);
    wr(8'h20, 32'h0);
    rd(8'h20);
    chk(rv, 32'h04000000);
    chk(coax_mode_r, 1'b0);
    aux(2'h1);
    rd(8'h34);
    chk(rv[1:0], 2'h2);
    wr(8'h40, 32'hff);
    chk(resp, 2'h2);
    $display("t_audio done");
  endtask
  // Remote side is taken to be in auto-acknowledge for rate changes
  task t_rate;
    wr(8'h30, 32'h2080);
    wr(8'h20, 32'h40);
    chk(oscillator_divider_div_r, 8'h40);
    wr(8'h20, 32'h0);
    chk(oscillator_divider_div_r, 8'h20);
    wr(8'h20, 32'h50);
    chk({resp, back_channel_fast_rate_r, oscillator_divider_div_r}, 32'h100);
    $display("t_rate done");
  endtask
  task t_osc;
    logic [5:0] mhz [4] = '{6'h32, 6'h19, 6'h0a, 6'h00};
    for (int r = 0; r < 4; r++) begin
      wr(8'h24, 32'(r << 4));
      chk({oscillator_rx_clock_rate_r, rx_clock_mhz_r}, {r[1:0], mhz[r]});
    end
    wr(8'h30, 32'h80);
    chk(rx_clock_mhz_r, 6'h00);
    $display("t_osc done");
  endtask
  task wait_remote;
    repeat (3) @(posedge aclk);
    for (int n = 0; n < 20 && remote_wr_req_r !== 1'b0; n++) @(posedge aclk);
  endtask
  // Register-driven then pin-driven self test; remote answers slowly second time
  task t_bist;
    wr(8'h24, 32'h05);
    wait_remote;
    chk({selftest_active_r, selftest_cfg_r, rem_clk_src}, 6'h36);
    wr(8'h24, 32'h0a);
    rem_slow <= 1'b1;
    selftest_pin <= 1'b1;
    wait_remote;
    chk({selftest_active_r, selftest_cfg_r, rem_clk_src}, 6'h25);
    $display("t_bist done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset;
    t_audio;
    t_rate;
    t_osc;
    t_bist;
    complete_run;
  end
  // Whole run needs well under 2000 cycles
  initial begin
    #20000;
    miscompares++;
    complete_run;
  end
endmodule
`default_nettype wire
